// ==== cpu_alu_defines.svh ====
// register offsets, field positions and bus codes of the alu slice
`ifndef CPU_ALU_DEFINES_SVH
`define CPU_ALU_DEFINES_SVH

`define ALU_CTRL_OFFSET 8'h00
`define ALU_SRC_OFFSET 8'h04
`define ALU_DST_OFFSET 8'h08
`define ALU_SR_OFFSET 8'h0c

`define CTRL_OP_LSB 0
`define CTRL_OP_MSB 3
`define CTRL_BYTE_BIT 4
`define CTRL_REG_BIT 5

`define SR_C_BIT 0
`define SR_Z_BIT 1
`define SR_N_BIT 2
`define SR_GIE_BIT 3
`define SR_PROCESSOR_OFF_BIT_BIT 4
`define SR_OSCILLATOR_OFF_BIT_BIT 5
`define SR_V_BIT 8

`define SR_RESET 16'h0000
`define SRC_RESET 20'h00000
`define DST_RESET 20'h00000
`define CTRL_RESET 6'h00

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ==== cpu_alu_pkg.sv ====
// types and shared helpers of the alu slice
package cpu_alu_pkg;

	typedef enum logic [3:0] {
		op_none,
		set_carry_op,
		set_negative_op,
		set_zero_op,
		subtract_op,
		subtract_with_carry_op,
		byte_swap_op,
		sign_extend_op,
		test_against_zero_op,
		xor_op
	} op_t;

	typedef struct packed {
		logic v;
		logic n;
		logic z;
		logic c;
	} flags_t;

	typedef struct packed {
		op_t op;
		logic byte_form;
		logic reg_mode;
	} alu_req_t;

	typedef struct packed {
		logic [19:0] data;
		logic write;
		flags_t flags;
	} alu_res_t;

	// places a word or byte result into the 20-bit destination
	function automatic logic [19:0] write_back(input logic [19:0] dst, input logic [15:0] r,
		input logic byte_form, input logic reg_mode);
		if (reg_mode) begin
			write_back = byte_form ? {12'h000, r[7:0]} : {4'h0, r};
		end else begin
			write_back = byte_form ? {dst[19:8], r[7:0]} : {dst[19:16], r};
		end
	endfunction : write_back

	function automatic logic sign_of(input logic [15:0] r, input logic byte_form);
		sign_of = byte_form ? r[7] : r[15];
	endfunction : sign_of

	function automatic logic is_zero(input logic [15:0] r, input logic byte_form);
		is_zero = byte_form ? (r[7:0] == 8'h00) : (r == 16'h0000);
	endfunction : is_zero

endpackage : cpu_alu_pkg

// ==== alu_arith.sv ====
// subtract, subtract with carry and test against zero
`timescale 1ns/1ps
module alu_arith import cpu_alu_pkg::*; (
	input wire alu_req_t req,
	input wire logic [19:0] src,
	input wire logic [19:0] dst,
	input wire flags_t flags_in,
	output alu_res_t res
);
	logic [15:0] a;
	logic [15:0] b;
	logic cin;
	logic [16:0] sum;
	logic carry;
	logic sa;
	logic da;
	logic ra;
	logic is_test;

	always_comb begin
		is_test = (req.op == test_against_zero_op);
		a = dst[15:0];
		// test adds all ones plus one, i.e. a zero source
		b = is_test ? 16'hffff : ~src[15:0];
		cin = (req.op == subtract_with_carry_op) ? flags_in.c : 1'b1;
		if (req.byte_form) begin
			sum = {9'h000, a[7:0]} + {9'h000, b[7:0]} + {16'h0000, cin};
			carry = sum[8];
		end else begin
			sum = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
			carry = sum[16];
		end
		sa = is_test ? 1'b0 : sign_of(src[15:0], req.byte_form);
		da = sign_of(a, req.byte_form);
		ra = sign_of(sum[15:0], req.byte_form);
		res.flags.n = ra;
		res.flags.z = is_zero(sum[15:0], req.byte_form);
		res.flags.c = carry;
		res.flags.v = (sa & ~da & ra) | (~sa & da & ~ra);
		res.write = ~is_test;
		res.data = write_back(dst, sum[15:0], req.byte_form, req.reg_mode);
	end

endmodule : alu_arith

// ==== alu_logic.sv ====
// flag set operations, byte swap, sign extension and exclusive or
`timescale 1ns/1ps
module alu_logic import cpu_alu_pkg::*; (
	input wire alu_req_t req,
	input wire logic [19:0] src,
	input wire logic [19:0] dst,
	input wire flags_t flags_in,
	output alu_res_t res
);
	logic [15:0] r;
	logic byte_f;

	always_comb begin
		res.flags = flags_in;
		res.write = 1'b0;
		res.data = dst;
		byte_f = req.byte_form;
		r = 16'h0000;
		case (req.op)
			set_carry_op: begin
				res.flags.c = 1'b1;
			end
			set_negative_op: begin
				res.flags.n = 1'b1;
			end
			set_zero_op: begin
				res.flags.z = 1'b1;
			end
			byte_swap_op: begin
				r = {dst[7:0], dst[15:8]};
				res.write = 1'b1;
				// register form clears bits 19:16
				res.data = write_back(dst, r, 1'b0, req.reg_mode);
			end
			sign_extend_op: begin
				r = {{8{dst[7]}}, dst[7:0]};
				res.write = 1'b1;
				if (req.reg_mode) begin
					res.data = {{12{dst[7]}}, dst[7:0]};
				end else begin
					res.data = {dst[19:16], r};
				end
				res.flags.n = r[15];
				res.flags.z = (r == 16'h0000);
				res.flags.c = (r != 16'h0000);
				res.flags.v = 1'b0;
			end
			xor_op: begin
				r = src[15:0] ^ dst[15:0];
				res.write = 1'b1;
				res.data = write_back(dst, r, byte_f, req.reg_mode);
				res.flags.n = sign_of(r, byte_f);
				res.flags.z = is_zero(r, byte_f);
				res.flags.c = ~is_zero(r, byte_f);
				res.flags.v = sign_of(src[15:0], byte_f) & sign_of(dst[15:0], byte_f);
			end
			default: begin
				res.flags = flags_in;
			end
		endcase
	end

endmodule : alu_logic

// ==== cpu_alu_flag_sub_swap_ext_xor.sv ====
// alu slice with its axi4-lite register slave
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "cpu_alu_defines.svh"

// Operation
// - set carry forces C, other flags untouched
// - set negative forces N, other flags untouched
// - set zero forces Z, other flags untouched
// - subtract writes dst plus inverted src plus one; src unchanged
// - subtract sets N on negative, Z on equal, C on carry out
// - subtract forms set V on signed overflow, else clear
// - subtract with carry adds inverted src plus current carry
// - subtract with carry sets N, Z, C from its result
// - byte swap exchanges low and high byte, flags untouched
// - register byte swap clears bits 19 to 16
// - register sign extension copies bit 7 into bits 19 to 8
// - memory sign extension copies bit 7 into high byte only
// - sign extension sets N, Z, C as not Z, clears V
// - exclusive or writes src xor dst; src unchanged
// - xor sets N, Z, C as not Z, V when both negative
// - subtract, subtract with carry, test and xor have byte forms
// - mode bits of the status register are never changed by an operation, only by a software write
module cpu_alu_flag_sub_swap_ext_xor import cpu_alu_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axil_awaddr,
	input wire logic s_axil_awvalid,
	output logic s_axil_awready,
	input wire logic [31:0] s_axil_wdata,
	input wire logic [3:0] s_axil_wstrb,
	input wire logic s_axil_wvalid,
	output logic s_axil_wready,
	output logic [1:0] s_axil_bresp,
	output logic s_axil_bvalid,
	input wire logic s_axil_bready,
	input wire logic [7:0] s_axil_araddr,
	input wire logic s_axil_arvalid,
	output logic s_axil_arready,
	output logic [31:0] s_axil_rdata,
	output logic [1:0] s_axil_rresp,
	output logic s_axil_rvalid,
	input wire logic s_axil_rready
);
	logic [7:0] aw_addr;
	logic aw_held;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic w_held;
	logic do_write;
	logic addr_ok;
	logic [5:0] ctrl;
	logic [19:0] src;
	logic [19:0] dst;
	logic [15:0] status_register;
	logic exec;
	alu_req_t req;
	flags_t flags_now;
	alu_res_t arith_res;
	alu_res_t logic_res;
	alu_res_t sel_res;
	logic [15:0] next_sr;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;
	logic [31:0] ctrl_wr;
	logic [31:0] src_wr;
	logic [31:0] dst_wr;
	logic [31:0] sr_wr;

	// merges write data into an old value by byte lane
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				m[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		merge = m;
	endfunction : merge

	function automatic logic mapped(input logic [7:0] addr);
		mapped = (addr == `ALU_CTRL_OFFSET) || (addr == `ALU_SRC_OFFSET) ||
			(addr == `ALU_DST_OFFSET) || (addr == `ALU_SR_OFFSET);
	endfunction : mapped

	// old value of each register merged with the held write word
	assign ctrl_wr = merge({26'h0000000, ctrl}, w_data, w_strb);
	assign src_wr = merge({12'h000, src}, w_data, w_strb);
	assign dst_wr = merge({12'h000, dst}, w_data, w_strb);
	assign sr_wr = merge({16'h0000, status_register}, w_data, w_strb);

	// write address and data are taken in either order
	assign s_axil_awready = ~aw_held & ~s_axil_bvalid;
	assign s_axil_wready = ~w_held & ~s_axil_bvalid;
	assign do_write = aw_held & w_held & ~s_axil_bvalid;
	assign addr_ok = mapped(aw_addr);
	assign s_axil_arready = ~s_axil_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
		end else if (s_axil_awvalid && s_axil_awready) begin
			aw_held <= 1'b1;
			aw_addr <= {s_axil_awaddr[7:2], 2'b00};
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else if (s_axil_wvalid && s_axil_wready) begin
			w_held <= 1'b1;
			w_data <= s_axil_wdata;
			w_strb <= s_axil_wstrb;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	// write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axil_bvalid <= 1'b0;
			s_axil_bresp <= `RESP_OKAY;
		end else if (do_write) begin
			s_axil_bvalid <= 1'b1;
			s_axil_bresp <= addr_ok ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axil_bready) begin
			s_axil_bvalid <= 1'b0;
		end
	end

	// a write to the control register with byte lane 0 strobed launches one operation
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= `CTRL_RESET;
			exec <= 1'b0;
		end else begin
			exec <= do_write && (aw_addr == `ALU_CTRL_OFFSET) && w_strb[0];
			if (do_write && aw_addr == `ALU_CTRL_OFFSET) begin
				ctrl <= ctrl_wr[5:0];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			src <= `SRC_RESET;
		end else if (do_write && aw_addr == `ALU_SRC_OFFSET) begin
			src <= src_wr[19:0];
		end
	end

	always_comb begin
		req.op = op_t'(ctrl[`CTRL_OP_MSB:`CTRL_OP_LSB]);
		req.byte_form = ctrl[`CTRL_BYTE_BIT];
		req.reg_mode = ctrl[`CTRL_REG_BIT];
		flags_now.c = status_register[`SR_C_BIT];
		flags_now.z = status_register[`SR_Z_BIT];
		flags_now.n = status_register[`SR_N_BIT];
		flags_now.v = status_register[`SR_V_BIT];
	end

	alu_arith u_arith (
		.req(req),
		.src(src),
		.dst(dst),
		.flags_in(flags_now),
		.res(arith_res)
	);

	alu_logic u_logic (
		.req(req),
		.src(src),
		.dst(dst),
		.flags_in(flags_now),
		.res(logic_res)
	);

	always_comb begin
		case (req.op)
			subtract_op, subtract_with_carry_op, test_against_zero_op: begin
				sel_res = arith_res;
			end
			default: begin
				sel_res = logic_res;
			end
		endcase
		// only the four flags move; mode bits stay as they are
		next_sr = status_register;
		next_sr[`SR_C_BIT] = sel_res.flags.c;
		next_sr[`SR_Z_BIT] = sel_res.flags.z;
		next_sr[`SR_N_BIT] = sel_res.flags.n;
		next_sr[`SR_V_BIT] = sel_res.flags.v;
	end

	// destination: software write or operation result; src never written here
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dst <= `DST_RESET;
		end else if (exec && sel_res.write) begin
			dst <= sel_res.data;
		end else if (do_write && aw_addr == `ALU_DST_OFFSET) begin
			dst <= dst_wr[19:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_register <= `SR_RESET;
		end else if (exec) begin
			status_register <= next_sr;
		end else if (do_write && aw_addr == `ALU_SR_OFFSET) begin
			status_register <= sr_wr[15:0];
		end
	end

	// read path
	always_comb begin
		next_rresp = `RESP_OKAY;
		case ({s_axil_araddr[7:2], 2'b00})
			`ALU_CTRL_OFFSET: begin
				next_rdata = {26'h0000000, ctrl};
			end
			`ALU_SRC_OFFSET: begin
				next_rdata = {12'h000, src};
			end
			`ALU_DST_OFFSET: begin
				next_rdata = {12'h000, dst};
			end
			`ALU_SR_OFFSET: begin
				next_rdata = {16'h0000, status_register};
			end
			default: begin
				next_rdata = 32'h00000000;
				next_rresp = `RESP_SLVERR;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axil_rvalid <= 1'b0;
			s_axil_rdata <= 32'h00000000;
			s_axil_rresp <= `RESP_OKAY;
		end else if (s_axil_arvalid && s_axil_arready) begin
			s_axil_rvalid <= 1'b1;
			s_axil_rdata <= next_rdata;
			s_axil_rresp <= next_rresp;
		end else if (s_axil_rready) begin
			s_axil_rvalid <= 1'b0;
		end
	end

endmodule : cpu_alu_flag_sub_swap_ext_xor

// ==== alu_bus_checker_assertions.sv ====
// bus timing checker bound to the alu slice
`timescale 1ns/1ps
`include "cpu_alu_defines.svh"
module alu_bus_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axil_awvalid,
	input wire logic s_axil_awready,
	input wire logic s_axil_wvalid,
	input wire logic s_axil_wready,
	input wire logic [1:0] s_axil_bresp,
	input wire logic s_axil_bvalid,
	input wire logic s_axil_bready,
	input wire logic s_axil_arvalid,
	input wire logic s_axil_arready,
	input wire logic [31:0] s_axil_rdata,
	input wire logic [1:0] s_axil_rresp,
	input wire logic s_axil_rvalid,
	input wire logic s_axil_rready
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_taken;
		s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready;
	endsequence
	sequence s_b_late;
		!s_axil_bvalid ##1 s_axil_bvalid;
	endsequence
	a_reset_idle: assert property (disable iff (1'h0) !aresetn |=> !s_axil_bvalid && !s_axil_rvalid)
		else $error("valid after reset");
	a_b_latency: assert property (s_wr_taken |=> s_b_late)
		else $error("write answer late or early");
	a_b_cause: assert property ($rose(s_axil_bvalid) |-> $past(s_axil_wvalid && s_axil_wready, 2))
		else $error("write answer without write");
	a_b_hold: assert property (s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid && $stable(s_axil_bresp))
		else $error("write answer dropped");
	a_b_code: assert property (s_axil_bvalid |-> s_axil_bresp inside {`RESP_OKAY, `RESP_SLVERR})
		else $error("bad write response");
	a_w_blocked: assert property (s_axil_bvalid |-> !s_axil_awready && !s_axil_wready)
		else $error("write accepted while answering");
	a_r_latency: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid)
		else $error("read answer late");
	a_r_hold: assert property (s_axil_rvalid && !s_axil_rready |=>
		s_axil_rvalid && $stable(s_axil_rdata) && $stable(s_axil_rresp))
		else $error("read answer changed");
	a_r_once: assert property (s_axil_rvalid && s_axil_rready |=> !s_axil_rvalid)
		else $error("read answered twice");
	a_ar_blocked: assert property (s_axil_rvalid |-> !s_axil_arready)
		else $error("read accepted while answering");
endmodule : alu_bus_checker
bind cpu_alu_flag_sub_swap_ext_xor alu_bus_checker chk_i (.*);

// ==== alu_bus_master.sv ====
// decoder side model driving the register bus
`timescale 1ns/1ps
module alu_bus_master (
	input wire logic aclk,
	output logic [7:0] s_axil_awaddr,
	output logic s_axil_awvalid,
	input wire logic s_axil_awready,
	output logic [31:0] s_axil_wdata,
	output logic [3:0] s_axil_wstrb,
	output logic s_axil_wvalid,
	input wire logic s_axil_wready,
	input wire logic [1:0] s_axil_bresp,
	input wire logic s_axil_bvalid,
	output logic s_axil_bready,
	output logic [7:0] s_axil_araddr,
	output logic s_axil_arvalid,
	input wire logic s_axil_arready,
	input wire logic [31:0] s_axil_rdata,
	input wire logic [1:0] s_axil_rresp,
	input wire logic s_axil_rvalid,
	output logic s_axil_rready
);
	initial begin
		{s_axil_awaddr, s_axil_awvalid, s_axil_wdata, s_axil_wstrb, s_axil_wvalid} = '0;
		{s_axil_bready, s_axil_araddr, s_axil_arvalid, s_axil_rready} = '0;
	end
	task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw, w, b;
		{aw, w, b} = 3'h7;
		@(posedge aclk);
		s_axil_awaddr <= a;
		s_axil_wdata <= d;
		s_axil_wstrb <= 4'hf;
		{s_axil_awvalid, s_axil_wvalid, s_axil_bready} <= 3'h7;
		while (b) begin
			@(posedge aclk);
			if (aw && s_axil_awready) begin
				aw = 1'h0;
				s_axil_awvalid <= 1'h0;
			end
			if (w && s_axil_wready) begin
				w = 1'h0;
				s_axil_wvalid <= 1'h0;
			end
			if (s_axil_bvalid) begin
				r = s_axil_bresp;
				b = 1'h0;
				s_axil_bready <= 1'h0;
			end
		end
	endtask : wr
	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar, rv;
		{ar, rv} = 2'h3;
		@(posedge aclk);
		s_axil_araddr <= a;
		{s_axil_arvalid, s_axil_rready} <= 2'h3;
		while (rv) begin
			@(posedge aclk);
			if (ar && s_axil_arready) begin
				ar = 1'h0;
				s_axil_arvalid <= 1'h0;
			end
			if (s_axil_rvalid) begin
				{d, r} = {s_axil_rdata, s_axil_rresp};
				rv = 1'h0;
				s_axil_rready <= 1'h0;
			end
		end
	endtask : rd
endmodule : alu_bus_master

// ==== tb_cpu_alu_flag_sub_swap_ext_xor.sv ====
// self-checking bench of the alu slice
`timescale 1ns/1ps
`include "cpu_alu_defines.svh"
module tb_cpu_alu_flag_sub_swap_ext_xor import cpu_alu_pkg::*;;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] s_axil_awaddr, s_axil_araddr;
	logic [31:0] s_axil_wdata, s_axil_rdata, v;
	logic [3:0] s_axil_wstrb;
	logic [1:0] s_axil_bresp, s_axil_rresp, r;
	logic s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready, s_axil_bvalid;
	logic s_axil_bready, s_axil_arvalid, s_axil_arready, s_axil_rvalid, s_axil_rready;
	int miscompares = 0;
	int cmp_count = 0;
	always #25 aclk = ~aclk;
	cpu_alu_flag_sub_swap_ext_xor DUT (.*);
	alu_bus_master m (.*);
	task give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	task chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %0t data got %h exp %h", $time, g, e);
		end
	endtask : chk
	task chk_resp(input logic [1:0] g, input logic [1:0] e);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %0t resp got %h exp %h", $time, g, e);
		end
	endtask : chk_resp
	// loads operands and flags, runs one op, reads back dst, flags and src
	task run(input op_t op, input logic b, input logic rg, input logic [19:0] s,
		input logic [19:0] d, input logic [15:0] f, input logic [19:0] ed, input logic [15:0] ef);
		m.wr(`ALU_SRC_OFFSET, {12'h000, s}, r);
		m.wr(`ALU_DST_OFFSET, {12'h000, d}, r);
		m.wr(`ALU_SR_OFFSET, {16'h0000, f}, r);
		m.wr(`ALU_CTRL_OFFSET, {26'h0, rg, b, op}, r);
		chk_resp(r, `RESP_OKAY);
		m.rd(`ALU_DST_OFFSET, v, r);
		chk(v, {12'h000, ed});
		m.rd(`ALU_SR_OFFSET, v, r);
		chk(v, {16'h0000, ef});
		m.rd(`ALU_SRC_OFFSET, v, r);
		chk(v, {12'h000, s});
		chk_resp(r, `RESP_OKAY);
		$display("test %s done", op.name());
	endtask : run
	initial begin
		repeat (5000) @(posedge aclk);
		miscompares++;
		give_verdict;
	end
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		m.rd(`ALU_SR_OFFSET, v, r);
		chk(v, 32'h0);
		m.rd(`ALU_DST_OFFSET, v, r);
		chk(v, 32'h0);
		m.wr(8'h40, 32'h5, r);
		chk_resp(r, `RESP_SLVERR);
		m.rd(8'h40, v, r);
		chk_resp(r, `RESP_SLVERR);
		chk(v, 32'h0);
		$display("test unmapped done");
		run(op_none, 1'h0, 1'h0, 20'h0, 20'h12345, 16'h013f, 20'h12345, 16'h013f);
		run(set_carry_op, 1'h0, 1'h0, 20'h0, 20'h12345, 16'h0038, 20'h12345, 16'h0039);
		run(set_negative_op, 1'h0, 1'h0, 20'h0, 20'h12345, 16'h0103, 20'h12345, 16'h0107);
		run(set_zero_op, 1'h0, 1'h0, 20'h0, 20'h12345, 16'h0000, 20'h12345, 16'h0002);
		run(subtract_op, 1'h0, 1'h0, 20'h00001, 20'h50001, 16'h0038, 20'h50000, 16'h003b);
		run(subtract_op, 1'h0, 1'h1, 20'h00001, 20'h38000, 16'h0000, 20'h07fff, 16'h0101);
		run(subtract_op, 1'h1, 1'h1, 20'h00002, 20'h0ab01, 16'h0000, 20'h000ff, 16'h0004);
		run(subtract_with_carry_op, 1'h0, 1'h0, 20'h1, 20'h3, 16'h0000, 20'h1, 16'h0001);
		run(subtract_with_carry_op, 1'h0, 1'h0, 20'h1, 20'h1, 16'h0001, 20'h0, 16'h0003);
		run(byte_swap_op, 1'h0, 1'h1, 20'h0, 20'hf1234, 16'h0105, 20'h03412, 16'h0105);
		run(byte_swap_op, 1'h0, 1'h0, 20'h0, 20'hf1234, 16'h0105, 20'hf3412, 16'h0105);
		run(sign_extend_op, 1'h0, 1'h1, 20'h0, 20'h00080, 16'h0100, 20'hfff80, 16'h0005);
		run(sign_extend_op, 1'h0, 1'h0, 20'h0, 20'h5a37f, 16'h0106, 20'h5007f, 16'h0001);
		run(sign_extend_op, 1'h0, 1'h1, 20'h0, 20'h12300, 16'h0001, 20'h00000, 16'h0002);
		run(test_against_zero_op, 1'h0, 1'h0, 20'h12345, 20'h08000, 16'h0100, 20'h08000, 16'h0005);
		run(test_against_zero_op, 1'h1, 1'h0, 20'h12345, 20'h0ff00, 16'h0000, 20'h0ff00, 16'h0003);
		run(xor_op, 1'h0, 1'h1, 20'h08001, 20'h18003, 16'h0000, 20'h00002, 16'h0101);
		run(xor_op, 1'h1, 1'h0, 20'h000ff, 20'h123ff, 16'h0000, 20'h12300, 16'h0102);
		give_verdict;
	end
endmodule : tb_cpu_alu_flag_sub_swap_ext_xor
